// file: common/osc_ctrl_defs.svh
`ifndef OSC_CTRL_DEFS_SVH
`define OSC_CTRL_DEFS_SVH

// ****************************************
// Register map
// ****************************************
`define OSC_ADDR_WIDTH 4
`define OSC_CTRL_OFFSET 4'h0
`define OSC_UNLOCK_OFFSET 4'h4
`define OSC_UNLOCK_KEY1 32'haa996655
`define OSC_UNLOCK_KEY2 32'h556699aa

// ****************************************
// Field positions
// ****************************************
`define OSC_PLL_ODIV_LSB 27
`define OSC_RC_DIV_LSB 24
`define OSC_SOSC_RDY_BIT 22
`define OSC_PERIPHERAL_BUS_DIVISOR_RDY_BIT 21
`define OSC_PERIPHERAL_BUS_DIVISOR_LSB 19
`define OSC_PLL_MULT_LSB 16
`define OSC_CUR_SRC_LSB 12
`define OSC_NEW_SRC_LSB 8
`define OSC_SEL_LOCK_BIT 7
`define OSC_USB_LOCK_BIT 6
`define OSC_SYS_LOCK_BIT 5
`define OSC_SLEEP_BIT 4
`define OSC_FAIL_BIT 3
`define OSC_USB_RC_BIT 2
`define OSC_SOSC_EN_BIT 1
`define OSC_SWITCH_BIT 0

// ****************************************
// Reset values and timing
// ****************************************
`define OSC_RC_DIV_RESET 3'h1
`define OSC_PERIPHERAL_BUS_DIVISOR_RESET 2'h3
`define OSC_SWITCH_CYCLES 4'h8
`define OSC_PERIPHERAL_BUS_DIVISOR_BUSY_CYCLES 4'h4

`endif

// file: common/osc_ctrl_pkg.sv
package osc_ctrl_pkg;

	typedef struct packed {
		logic [2:0] pll_output_divider;
		logic [2:0] internal_rc_divider;
		logic [1:0] peripheral_bus_divisor;
		logic [2:0] pll_multiplier;
		logic [2:0] new_source_select;
		logic selection_lock;
		logic wait_enters_sleep;
		logic usb_internal_rc_enable;
		logic low_speed_osc_enable;
	} osc_ctrl_type;

	typedef struct packed {
		logic [2:0] initial_source_config;
		logic [1:0] switch_monitor_config;
		logic [2:0] pll_output_divider;
		logic [1:0] peripheral_bus_divisor;
		logic [2:0] pll_multiplier;
		logic low_speed_osc_enable;
	} osc_config_type;

	typedef struct packed {
		logic low_speed_osc_ready;
		logic usb_pll_locked;
		logic system_pll_locked;
		logic fail_safe_monitor;
	} osc_status_type;

	typedef enum logic [2:0] {
		SW_IDLE = 3'b001,
		SW_BUSY = 3'b010,
		SW_DONE = 3'b100
	} switch_state_type;

	typedef enum logic [2:0] {
		KEY_NONE = 3'b001,
		KEY_FIRST = 3'b010,
		KEY_OPEN = 3'b100
	} unlock_state_type;

endpackage

// file: logic/osc_sync.sv
`timescale 1ns/10ps
module osc_sync (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic [3:0] i_async,
	output logic [3:0] o_sync
);
	logic [3:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			meta_reg <= 4'h0;
			o_sync <= 4'h0;
		end else begin
			meta_reg <= i_async;
			o_sync <= meta_reg;
		end
	end
endmodule // osc_sync

// file: logic/osc_ctrl.sv
// Functional notes
// RULE_01 - Bits 29:27 pick PLL output divide 1,2,4,8,16,32,64,256.
// RULE_02 - Bits 26:24 pick internal RC divide, same table, reset divide by 2.
// RULE_03 - Bit 22 reads 1 only while low-speed oscillator is running and stable.
// RULE_04 - Bit 21 shows bus divisor writable; writes while 0 are dropped.
// RULE_05 - Bits 20:19 divide system clock by 1,2,4,8 for bus clock, default 11.
// RULE_06 - Bits 18:16 pick PLL multiply 15..21 or 24.
// RULE_07 - Bits 14:12 read back the active clock source, same encoding.
// RULE_08 - Bits 10:8 pick new source; reset loads them from configuration.
// RULE_09 - With monitor config 1x, lock bit 7 freezes clock and PLL fields.
// RULE_10 - With monitor config 0x, selections are never locked.
// RULE_11 - Bit 6 shows USB PLL locked or its start timer expired.
// RULE_12 - Bit 5 shows system PLL locked or its start timer satisfied.
// RULE_13 - Bit 4 set makes wait enter sleep, clear makes it idle.
// RULE_14 - Bit 3 sets when the fail-safe monitor sees a clock failure.
// RULE_15 - Writes take effect only right after the unlock key sequence.
// RULE_16 - Bits 31:30, 23, 15 and 11 read zero and ignore writes.
// RULE_17 - Writing 1 to bit 0 starts a switch; hardware clears it at the end.
// RULE_18 - Bit 1 turns the low-speed oscillator on or off.
// RULE_19 - Bit 2 routes internal RC to USB clock, else primary or USB PLL.
// RULE_20 - Current source follows new source only once the switch completes.
// RULE_21 - Failure flag stays until software clears it under unlock.
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`include "osc_ctrl_defs.svh"
module osc_ctrl
	import osc_ctrl_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic [`OSC_ADDR_WIDTH-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire osc_config_type i_config,
	input wire osc_status_type i_status,
	output osc_ctrl_type o_ctrl,
	output logic [2:0] o_current_source,
	output logic [8:0] o_pll_out_divide,
	output logic [8:0] o_rc_divide,
	output logic [3:0] o_bus_divide,
	output logic [4:0] o_pll_multiply,
	output logic o_switch_busy,
	output logic o_clock_failure
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [8:0] div_of(input logic [2:0] code);
		logic [8:0] r;
		r = 9'h001;
		case (code)
			3'h7: r = 9'h100;
			default: r = 9'(9'h001 << code);
		endcase
		return r;
	endfunction

	function automatic logic [4:0] mult_of(input logic [2:0] code);
		logic [4:0] r;
		r = 5'h18;
		if (code != 3'h7) begin
			r = 5'(5'h0f + {2'h0, code});
		end
		return r;
	endfunction

	// Three-bit fields share one extractor so positions stay in the header
	function automatic logic [2:0] field3(input logic [31:0] word, input int lsb);
		logic [2:0] f;
		f = word[lsb +: 3];
		return f;
	endfunction

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [3:0] status_sync;
	osc_status_type st;

	osc_sync u_sync (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_async(i_status),
		.o_sync(status_sync)
	);
	assign st = osc_status_type'(status_sync);

	// Strap levels carry no reset here; reset must span two edges so that
	// these stages hold a clean copy by the first edge after release
	osc_config_type cfg_meta_reg;
	osc_config_type cfg_sync_reg;

	always_ff @(posedge i_clk_sys) begin
		cfg_meta_reg <= i_config;
		cfg_sync_reg <= cfg_meta_reg;
	end

	// ****************************************
	// Configuration capture at reset release
	// ****************************************
	logic cfg_loaded_reg;
	logic [1:0] monitor_cfg_reg;

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cfg_loaded_reg <= 1'b0;
			monitor_cfg_reg <= 2'h0;
		end else if (!cfg_loaded_reg) begin
			cfg_loaded_reg <= 1'b1;
			monitor_cfg_reg <= cfg_sync_reg.switch_monitor_config;
		end
	end

	// ****************************************
	// Unlock sequence
	// ****************************************
	unlock_state_type unlock_reg;
	logic wr_ctrl;
	logic wr_key;
	logic unlocked;

	assign wr_key = i_wr && (i_addr == `OSC_UNLOCK_OFFSET);
	assign unlocked = (unlock_reg == KEY_OPEN);
	assign wr_ctrl = i_wr && (i_addr == `OSC_CTRL_OFFSET) && unlocked; // [RULE_15]

	// Any write other than the expected key restores protection again
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			unlock_reg <= KEY_NONE;
		end else if (wr_key && i_wdata == `OSC_UNLOCK_KEY1) begin
			unlock_reg <= KEY_FIRST;
		end else if (i_wr) begin
			case (unlock_reg)
				KEY_FIRST: begin
					if (wr_key && i_wdata == `OSC_UNLOCK_KEY2) begin
						unlock_reg <= KEY_OPEN;
					end else begin
						unlock_reg <= KEY_NONE; // [RULE_15]
					end
				end
				default: begin
					unlock_reg <= KEY_NONE; // [RULE_15]
				end
			endcase
		end
	end

	// ****************************************
	// Control fields
	// ****************************************
	osc_ctrl_type ctrl_reg;
	logic sel_frozen;
	logic peripheral_bus_divisor_ok_reg;
	logic [3:0] peripheral_bus_divisor_cnt_reg;
	logic switch_reg;

	// Lock bit only bites when switching and monitoring is disabled
	assign sel_frozen = monitor_cfg_reg[1] && ctrl_reg.selection_lock; // [RULE_09] [RULE_10]

	// ****************************************
	// Write decode
	// ****************************************
	logic [1:0] peripheral_bus_divisor_wr;
	logic peripheral_bus_divisor_change;
	logic switch_start;

	assign peripheral_bus_divisor_wr = i_wdata[`OSC_PERIPHERAL_BUS_DIVISOR_LSB +: 2];
	// Rewriting the same divisor would block divisor writes for nothing
	assign peripheral_bus_divisor_change = wr_ctrl && peripheral_bus_divisor_ok_reg &&
		(peripheral_bus_divisor_wr != ctrl_reg.peripheral_bus_divisor);
	assign switch_start = wr_ctrl && i_wdata[`OSC_SWITCH_BIT] && !sel_frozen; // [RULE_17]

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			ctrl_reg <= '0;
			ctrl_reg.internal_rc_divider <= `OSC_RC_DIV_RESET; // [RULE_02]
			ctrl_reg.peripheral_bus_divisor <= `OSC_PERIPHERAL_BUS_DIVISOR_RESET; // [RULE_05]
		end else if (!cfg_loaded_reg) begin
			ctrl_reg.new_source_select <= cfg_sync_reg.initial_source_config; // [RULE_08]
			ctrl_reg.pll_output_divider <= cfg_sync_reg.pll_output_divider;
			ctrl_reg.pll_multiplier <= cfg_sync_reg.pll_multiplier;
			ctrl_reg.peripheral_bus_divisor <= cfg_sync_reg.peripheral_bus_divisor;
			ctrl_reg.low_speed_osc_enable <= cfg_sync_reg.low_speed_osc_enable;
		end else if (wr_ctrl) begin
			// Reserved bits are never stored [RULE_16]
			ctrl_reg.internal_rc_divider <= field3(i_wdata, `OSC_RC_DIV_LSB); // [RULE_02]
			ctrl_reg.wait_enters_sleep <= i_wdata[`OSC_SLEEP_BIT]; // [RULE_13]
			ctrl_reg.usb_internal_rc_enable <= i_wdata[`OSC_USB_RC_BIT]; // [RULE_19]
			ctrl_reg.low_speed_osc_enable <= i_wdata[`OSC_SOSC_EN_BIT]; // [RULE_18]
			if (!sel_frozen) begin
				ctrl_reg.pll_output_divider <= field3(i_wdata, `OSC_PLL_ODIV_LSB); // [RULE_01]
				ctrl_reg.pll_multiplier <= field3(i_wdata, `OSC_PLL_MULT_LSB); // [RULE_06]
				ctrl_reg.new_source_select <= field3(i_wdata, `OSC_NEW_SRC_LSB); // [RULE_08]
				ctrl_reg.selection_lock <= i_wdata[`OSC_SEL_LOCK_BIT]; // [RULE_09]
			end
			if (peripheral_bus_divisor_ok_reg) begin
				ctrl_reg.peripheral_bus_divisor <= peripheral_bus_divisor_wr; // [RULE_04]
			end
		end
	end

	// ****************************************
	// Bus divisor ready: busy while the new divide settles
	// ****************************************
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			peripheral_bus_divisor_ok_reg <= 1'b1;
			peripheral_bus_divisor_cnt_reg <= 4'h0;
		end else if (peripheral_bus_divisor_change) begin
			peripheral_bus_divisor_ok_reg <= 1'b0; // [RULE_04]
			peripheral_bus_divisor_cnt_reg <= `OSC_PERIPHERAL_BUS_DIVISOR_BUSY_CYCLES;
		end else if (peripheral_bus_divisor_cnt_reg != 4'h0) begin
			peripheral_bus_divisor_cnt_reg <= peripheral_bus_divisor_cnt_reg - 4'h1;
			peripheral_bus_divisor_ok_reg <= peripheral_bus_divisor_cnt_reg == 4'h1;
		end
	end

	// ****************************************
	// Clock switch sequencer
	// ****************************************
	switch_state_type sw_state_reg;
	logic [3:0] sw_cnt_reg;
	logic [2:0] cur_src_reg;

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			sw_state_reg <= SW_IDLE;
			sw_cnt_reg <= 4'h0;
			switch_reg <= 1'b0;
			cur_src_reg <= 3'h0;
		end else if (!cfg_loaded_reg) begin
			cur_src_reg <= cfg_sync_reg.initial_source_config;
		end else begin
			case (sw_state_reg)
				SW_IDLE: begin
					if (switch_start) begin
						switch_reg <= 1'b1; // [RULE_17]
						sw_cnt_reg <= `OSC_SWITCH_CYCLES;
						sw_state_reg <= SW_BUSY;
					end
				end
				SW_BUSY: begin
					if (sw_cnt_reg == 4'h1) begin
						sw_state_reg <= SW_DONE;
					end
					sw_cnt_reg <= sw_cnt_reg - 4'h1;
				end
				SW_DONE: begin
					// Source changes only when the switch finishes [RULE_20]
					cur_src_reg <= ctrl_reg.new_source_select; // [RULE_07]
					switch_reg <= 1'b0; // [RULE_17]
					sw_state_reg <= SW_IDLE;
				end
				default: begin
					sw_state_reg <= SW_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Clock failure flag
	// ****************************************
	logic fail_reg;

	// A failure in the clearing cycle wins over the clear
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			fail_reg <= 1'b0;
		end else if (st.fail_safe_monitor) begin
			fail_reg <= 1'b1; // [RULE_14]
		end else if (wr_ctrl) begin
			fail_reg <= i_wdata[`OSC_FAIL_BIT]; // [RULE_21]
		end
	end

	// ****************************************
	// Read-back
	// ****************************************
	logic [31:0] ctrl_word;

	always_comb begin
		ctrl_word = 32'h0; // [RULE_16]
		ctrl_word[`OSC_PLL_ODIV_LSB +: 3] = ctrl_reg.pll_output_divider;
		ctrl_word[`OSC_RC_DIV_LSB +: 3] = ctrl_reg.internal_rc_divider;
		ctrl_word[`OSC_SOSC_RDY_BIT] = st.low_speed_osc_ready && ctrl_reg.low_speed_osc_enable; // [RULE_03]
		ctrl_word[`OSC_PERIPHERAL_BUS_DIVISOR_RDY_BIT] = peripheral_bus_divisor_ok_reg; // [RULE_04]
		ctrl_word[`OSC_PERIPHERAL_BUS_DIVISOR_LSB +: 2] = ctrl_reg.peripheral_bus_divisor;
		ctrl_word[`OSC_PLL_MULT_LSB +: 3] = ctrl_reg.pll_multiplier;
		ctrl_word[`OSC_CUR_SRC_LSB +: 3] = cur_src_reg; // [RULE_07]
		ctrl_word[`OSC_NEW_SRC_LSB +: 3] = ctrl_reg.new_source_select;
		ctrl_word[`OSC_SEL_LOCK_BIT] = ctrl_reg.selection_lock;
		ctrl_word[`OSC_USB_LOCK_BIT] = st.usb_pll_locked; // [RULE_11]
		ctrl_word[`OSC_SYS_LOCK_BIT] = st.system_pll_locked; // [RULE_12]
		ctrl_word[`OSC_SLEEP_BIT] = ctrl_reg.wait_enters_sleep;
		ctrl_word[`OSC_FAIL_BIT] = fail_reg;
		ctrl_word[`OSC_USB_RC_BIT] = ctrl_reg.usb_internal_rc_enable;
		ctrl_word[`OSC_SOSC_EN_BIT] = ctrl_reg.low_speed_osc_enable;
		ctrl_word[`OSC_SWITCH_BIT] = switch_reg;
	end

	// Unlock register and unmapped addresses read zero
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rdata <= 32'h0;
		end else if (i_rd && i_addr == `OSC_CTRL_OFFSET) begin
			o_rdata <= ctrl_word;
		end else begin
			o_rdata <= 32'h0;
		end
	end

	// ****************************************
	// Registered outputs
	// ****************************************
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_ctrl <= '0;
			o_current_source <= 3'h0;
			o_switch_busy <= 1'b0;
			o_clock_failure <= 1'b0;
		end else begin
			o_ctrl <= ctrl_reg;
			o_current_source <= cur_src_reg;
			o_switch_busy <= switch_reg;
			o_clock_failure <= fail_reg;
		end
	end

	// Decoded ratios leave through flops so the clock tree never sees decode glitches
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_pll_out_divide <= 9'h001;
			o_rc_divide <= 9'h001;
			o_bus_divide <= 4'h1;
			o_pll_multiply <= 5'h0f;
		end else begin
			o_pll_out_divide <= div_of(ctrl_reg.pll_output_divider); // [RULE_01]
			o_rc_divide <= div_of(ctrl_reg.internal_rc_divider); // [RULE_02]
			o_bus_divide <= 4'(4'h1 << ctrl_reg.peripheral_bus_divisor); // [RULE_05]
			o_pll_multiply <= mult_of(ctrl_reg.pll_multiplier); // [RULE_06]
		end
	end

endmodule // osc_ctrl

// file: test/osc_ctrl_sva.sv
`timescale 1ns/10ps
module osc_ctrl_sva
	import osc_ctrl_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire osc_status_type i_status,
	input wire osc_ctrl_type o_ctrl,
	input wire logic [2:0] o_current_source,
	input wire logic [8:0] o_pll_out_divide,
	input wire logic [8:0] o_rc_divide,
	input wire logic [3:0] o_bus_divide,
	input wire logic [4:0] o_pll_multiply,
	input wire logic o_switch_busy,
	input wire logic o_clock_failure
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	// Divide table has a gap: code 7 jumps to 256, not 128
	function automatic logic [8:0] dv(input logic [2:0] c);
		return (c == 3'h7) ? 9'h100 : 9'h001 << c;
	endfunction
	property p_rsv; $past(i_rd) |-> (o_rdata & 32'hc0808800) == 32'h0; endproperty
	property p_pll; o_pll_out_divide == dv(o_ctrl.pll_output_divider); endproperty
	property p_rc; o_rc_divide == dv(o_ctrl.internal_rc_divider); endproperty
	property p_bus; o_bus_divide == 4'h1 << o_ctrl.peripheral_bus_divisor; endproperty
	property p_mul;
		o_pll_multiply == ((o_ctrl.pll_multiplier == 3'h7) ? 5'h18 : 5'hf + o_ctrl.pll_multiplier);
	endproperty
	property p_fset; i_status.fail_safe_monitor |-> ##[1:5] o_clock_failure; endproperty
	property p_fhold; $fell(o_clock_failure) |-> $past(i_wr, 2); endproperty
	// Busy stands nine samples: eight counted cycles plus the completion cycle
	property p_sw;
		$rose(o_switch_busy) |-> o_switch_busy [*8] ##1 o_switch_busy ##1 !o_switch_busy;
	endproperty
	property p_cur;
		$changed(o_current_source) |-> !o_switch_busy && o_current_source == o_ctrl.new_source_select;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
	a_pll: assert property (p_pll) else $error("pll divide wrong");
	a_rc: assert property (p_rc) else $error("rc divide wrong");
	a_bus: assert property (p_bus) else $error("bus divide wrong");
	a_mul: assert property (p_mul) else $error("pll multiply wrong");
	a_fset: assert property (p_fset) else $error("failure flag not set");
	a_fhold: assert property (p_fhold) else $error("failure flag dropped alone");
	a_sw: assert property (p_sw) else $error("switch length wrong");
	a_cur: assert property (p_cur) else $error("current source changed early");
	c_sw: cover property ($rose(o_switch_busy));
	c_fail: cover property ($rose(o_clock_failure));
	c_rd: cover property (i_rd ##1 o_rdata != 32'h0);
endmodule // osc_ctrl_sva

bind osc_ctrl osc_ctrl_sva u_osc_ctrl_sva (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_wr(i_wr),
	.i_rd(i_rd), .o_rdata(o_rdata), .i_status(i_status), .o_ctrl(o_ctrl),
	.o_current_source(o_current_source), .o_pll_out_divide(o_pll_out_divide),
	.o_rc_divide(o_rc_divide), .o_bus_divide(o_bus_divide), .o_pll_multiply(o_pll_multiply),
	.o_switch_busy(o_switch_busy), .o_clock_failure(o_clock_failure));

// file: test/osc_ctrl_tb.sv
`timescale 1ns/10ps
`include "osc_ctrl_defs.svh"
module osc_ctrl_tb
	import osc_ctrl_pkg::*;
;
	logic i_clk_sys, i_rstn, i_wr, i_rd, o_switch_busy, o_clock_failure;
	logic [3:0] i_addr;
	logic [31:0] i_wdata, o_rdata, rdat, ex;
	osc_config_type i_config;
	osc_status_type i_status;
	osc_ctrl_type o_ctrl;
	logic [2:0] o_current_source, c;
	logic [8:0] o_pll_out_divide, o_rc_divide;
	logic [3:0] o_bus_divide;
	logic [4:0] o_pll_multiply;
	int mismatches, num_checks, n;
	osc_ctrl u_osc_ctrl (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_config(i_config),
		.i_status(i_status), .o_ctrl(o_ctrl), .o_current_source(o_current_source),
		.o_pll_out_divide(o_pll_out_divide), .o_rc_divide(o_rc_divide),
		.o_bus_divide(o_bus_divide), .o_pll_multiply(o_pll_multiply),
		.o_switch_busy(o_switch_busy), .o_clock_failure(o_clock_failure));
	initial begin
		i_clk_sys = 1'b0;
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end
	// ****************************************
	// Bus tasks
	// ****************************************
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Strobe is left high so chained writes land in consecutive cycles
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
	endtask
	task uwr(input logic [31:0] d);
		wr(`OSC_UNLOCK_OFFSET, `OSC_UNLOCK_KEY1);
		wr(`OSC_UNLOCK_OFFSET, `OSC_UNLOCK_KEY2);
		wr(`OSC_CTRL_OFFSET, d);
	endtask
	task idle(input int k);
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
		repeat (k) @(posedge i_clk_sys);
	endtask
	task rd;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		i_addr <= `OSC_CTRL_OFFSET;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1 rdat = o_rdata;
	endtask
	task wt(input bit fail);
		n = 0;
		while ((fail ? o_clock_failure !== 1'b1 : o_switch_busy !== 1'b0) && n < 30) begin
			@(posedge i_clk_sys);
			#1 n++;
		end
		if (n >= 30) begin
			mismatches++;
			test_done();
		end
	endtask
	task rst;
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		i_rstn <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{i_wr, i_rd, i_addr, i_wdata, i_status} = '0;
		i_config = {3'h2, 2'h0, 3'h1, 2'h3, 3'h0, 1'h1};
		i_rstn = 1'b0;
		rst();
		rd();
		chk(rdat, 32'h09382202);
		wr(`OSC_UNLOCK_OFFSET, `OSC_UNLOCK_KEY1);
		wr(`OSC_CTRL_OFFSET, 32'h00000010);
		rd();
		chk(rdat, 32'h09382202);
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			uwr({2'h3, c, c, 3'h4, 2'h3, c, 4'h8, 1'h1, c, 8'h02});
			idle(2);
			ex = (c == 3'h7) ? 32'h100 : 32'h1 << c;
			chk(32'(o_pll_out_divide), ex);
			chk(32'(o_rc_divide), ex);
			chk(32'(o_pll_multiply), (c == 3'h7) ? 32'h18 : 32'hf + c);
			rd();
			chk(rdat, {2'h0, c, c, 3'h1, 2'h3, c, 4'h2, 1'h0, c, 8'h02});
		end
		uwr(32'h3b070516);
		uwr(32'h3b170516);
		idle(8);
		rd();
		chk(rdat, 32'h3b272516);
		chk(32'(o_bus_divide), 32'h1);
		chk(32'(o_ctrl.wait_enters_sleep), 32'h1);
		chk(32'(o_ctrl.usb_internal_rc_enable), 32'h1);
		uwr(32'h3b070596);
		uwr(32'h3b000596);
		idle(2);
		chk(32'(o_pll_multiply), 32'hf);
		uwr(32'h3b000597);
		idle(2);
		chk(32'(o_switch_busy), 32'h1);
		chk(32'(o_current_source), 32'h2);
		wt(1'b0);
		chk(32'(o_current_source), 32'h5);
		rd();
		chk(rdat & 32'h00007001, 32'h00005000);
		@(posedge i_clk_sys);
		i_status <= 4'he;
		idle(4);
		rd();
		chk(rdat & 32'h00400060, 32'h00400060);
		uwr(32'h3b000594);
		idle(2);
		chk(32'(o_ctrl.low_speed_osc_enable), 32'h0);
		rd();
		chk(rdat & 32'h00400002, 32'h0);
		@(posedge i_clk_sys);
		i_status <= 4'h1;
		wt(1'b1);
		@(posedge i_clk_sys);
		i_status <= 4'h0;
		idle(6);
		chk(32'(o_clock_failure), 32'h1);
		rd();
		chk(rdat & 32'h8, 32'h8);
		uwr(32'h3b000594);
		idle(3);
		chk(32'(o_clock_failure), 32'h0);
		@(posedge i_clk_sys);
		i_config <= {3'h2, 2'h2, 3'h1, 2'h3, 3'h0, 1'h1};
		rst();
		uwr(32'h3b1f0596);
		uwr(32'h3b180497);
		idle(3);
		chk(32'(o_pll_multiply), 32'h18);
		chk(32'(o_switch_busy), 32'h0);
		rd();
		chk(rdat & 32'h00070701, 32'h00070500);
		test_done();
	end
endmodule // osc_ctrl_tb
